// [logic/fcm_clk_divider.v]
// Divides a synchronised clock level by a power of two selected at run time.
`timescale 1ns/100ps
module fcm_clk_divider #(
   parameter RDIV_W = 3
) (
   // Clock and reset
   input wire hclk,
   input wire hresetn,
   // Source and divide select
   input wire src_lvl,
   input wire [RDIV_W-1:0] rdiv_sel,
   // Divided clock level
   output reg div_out_ff
);
   localparam CNT_W = (1 << RDIV_W) - 1;

   reg src_prev_ff;
   reg [CNT_W-1:0] cnt_ff;

   // Counting source rising edges gives a divide by two to the power rdiv_sel.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         src_prev_ff <= 1'b0;
         cnt_ff <= {CNT_W{1'b0}};
         div_out_ff <= 1'b0;
      end else begin
         src_prev_ff <= src_lvl;
         if (src_lvl && !src_prev_ff) begin
            cnt_ff <= cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
         end
         if (rdiv_sel == {RDIV_W{1'b0}}) begin
            div_out_ff <= src_lvl;
         end else begin
            div_out_ff <= cnt_ff[rdiv_sel - 1'b1];
         end
      end
   end
endmodule

// [logic/fcm_consts.vh]
// Constants for the clock generator mode controller: offsets, fields, codes and reset values.
`ifndef FCM_CONSTS_VH
`define FCM_CONSTS_VH

// Register byte offsets.
`define FCM_OFF_CTRL 8'h00
`define FCM_OFF_STATUS 8'h04
`define FCM_OFF_INT_STATUS 8'h08
`define FCM_OFF_INT_MASK 8'h0C
`define FCM_OFF_FILTER 8'h10

// Control register fields.
`define FCM_CTRL_SEL_LSB 0
`define FCM_CTRL_REFSEL_BIT 2
`define FCM_CTRL_RANGE_BIT 3
`define FCM_CTRL_OFF_BIT 4
`define FCM_CTRL_MULT_LSB 8
`define FCM_CTRL_RDIV_LSB 12
`define FCM_CTRL_RESET 32'h0000_0000

// Clock select field encodings.
`define FCM_SEL_SELF 2'h0
`define FCM_SEL_INT 2'h1
`define FCM_SEL_BYP 2'h2
`define FCM_SEL_EXT 2'h3

// Mode codes as seen in the status register.
`define FCM_MODE_SELF 3'h0
`define FCM_MODE_INT_UNLK 3'h1
`define FCM_MODE_INT_LOCK 3'h2
`define FCM_MODE_BYP 3'h3
`define FCM_MODE_EXT 3'h4
`define FCM_MODE_OFF 3'h5

// Status register fields.
`define FCM_STAT_MODE_LSB 0
`define FCM_STAT_LOCK_BIT 4
`define FCM_STAT_REF_OK_BIT 5
`define FCM_STAT_CLK_LOST_BIT 6
`define FCM_STAT_OSC_STABLE_BIT 7

// Interrupt status and mask bits.
`define FCM_INT_W 4
`define FCM_INT_LOCK_GAIN 0
`define FCM_INT_LOCK_LOST 1
`define FCM_INT_CLK_LOSS 2
`define FCM_INT_MODE_CHG 3
`define FCM_INT_MASK_RESET 4'h0

// Lock detector and averaging defaults.
`define FCM_ERR_W 16
`define FCM_LOCK_SAMPLES 4
`define FCM_LOCK_MAX 8
`define FCM_LOCK_MIN -8
`define FCM_UNLOCK_MAX 16
`define FCM_UNLOCK_MIN -16
`define FCM_AVG_SHIFT 2
`define FCM_RDIV_W 3

`endif

// [logic/fcm_mode_ctrl.v]
// Clock generator mode controller with lock tracking, filter averaging and AHB-Lite registers.
`timescale 1ns/100ps
`include "fcm_consts.vh"
module fcm_mode_ctrl #(
   parameter ERR_W = `FCM_ERR_W,
   parameter LOCK_SAMPLES = `FCM_LOCK_SAMPLES,
   parameter LOCK_MAX = `FCM_LOCK_MAX,
   parameter LOCK_MIN = `FCM_LOCK_MIN,
   parameter UNLOCK_MAX = `FCM_UNLOCK_MAX,
   parameter UNLOCK_MIN = `FCM_UNLOCK_MIN
) (
   // Clock and reset
   input wire hclk,
   input wire hresetn,
   // AHB-Lite slave
   input wire hsel,
   input wire [7:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata_ff,
   output reg hreadyout_ff,
   output reg hresp_ff,
   // Status flags and clocks from the analog side
   input wire ext_ref_status_pin,
   input wire loss_of_clock_pin,
   input wire osc_stable_pin,
   input wire osc_derived_clk_pin,
   input wire ext_ref_clk_pin,
   // Count error from the subtractor, one sample per comparison cycle
   input wire signed [ERR_W-1:0] count_error,
   input wire count_error_valid,
   // Oscillator and loop control
   output reg dco_enable_ff,
   output reg ref_gen_enable_ff,
   output reg loop_ext_ref_ff,
   output reg ref_select_ff,
   output reg range_ff,
   output reg [2:0] mult_factor_ff,
   output reg signed [ERR_W-1:0] filter_value_ff,
   output reg [2:0] mode_ff,
   output reg locked_ff,
   output wire generator_output_clk,
   output reg irq_ff
);
   localparam ST_SELF = `FCM_MODE_SELF;
   localparam ST_INT_UNLK = `FCM_MODE_INT_UNLK;
   localparam ST_INT_LOCK = `FCM_MODE_INT_LOCK;
   localparam ST_BYP = `FCM_MODE_BYP;
   localparam ST_EXT = `FCM_MODE_EXT;
   localparam ST_OFF = `FCM_MODE_OFF;
   localparam CNT_W = 8;
   localparam IW = `FCM_INT_W;

   // Synchroniser order: reference status, clock loss, oscillator stable, oscillator clock, reference clock.
   reg [4:0] meta_ff;
   reg [4:0] sync_ff;
   wire ref_ok = sync_ff[0];
   wire clk_lost = sync_ff[1];
   wire osc_stable = sync_ff[2];
   reg osc_stable_prev_ff;

   reg [31:0] ctrl_ff;
   reg [IW-1:0] int_stat_ff;
   reg [IW-1:0] int_mask_ff;
   reg [2:0] nxt_mode;
   reg [CNT_W-1:0] lock_cnt_ff;
   reg [CNT_W-1:0] nxt_lock_cnt;
   reg [1:0] avg_cnt_ff;
   reg signed [ERR_W+1:0] acc_ff;
   reg signed [ERR_W+1:0] sum;
   reg off_clock_select_field_byp_ff;
   reg off_clock_select_field_ext_ff;
   reg off_ext_pend_ff;
   reg [IW-1:0] evt;

   wire [1:0] clk_sel = ctrl_ff[`FCM_CTRL_SEL_LSB+1:`FCM_CTRL_SEL_LSB];
   wire off_req = ctrl_ff[`FCM_CTRL_OFF_BIT];
   wire [2:0] rdiv_sel = ctrl_ff[`FCM_CTRL_RDIV_LSB+2:`FCM_CTRL_RDIV_LSB];

   wire err_in_lock = (count_error > LOCK_MIN) && (count_error < LOCK_MAX);
   wire err_out_unlock = (count_error > UNLOCK_MAX) || (count_error < UNLOCK_MIN);

   // AHB-Lite address and data phase tracking.
   reg wr_pend_ff;
   reg rd_pend_ff;
   reg [7:0] addr_ff;
   wire addr_take = hsel && hready && htrans[1];
   wire wr_ctrl = wr_pend_ff && (addr_ff == `FCM_OFF_CTRL);
   wire wr_int_stat = wr_pend_ff && (addr_ff == `FCM_OFF_INT_STATUS);
   wire wr_int_mask = wr_pend_ff && (addr_ff == `FCM_OFF_INT_MASK);

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_ff <= 5'h00;
         sync_ff <= 5'h00;
         osc_stable_prev_ff <= 1'b0;
      end else begin
         meta_ff <= {ext_ref_clk_pin, osc_derived_clk_pin, osc_stable_pin, loss_of_clock_pin,
            ext_ref_status_pin};
         sync_ff <= meta_ff;
         osc_stable_prev_ff <= osc_stable;
      end
   end

   // Mode selection.
   always @* begin
      nxt_mode = mode_ff;
      case (mode_ff)
         ST_SELF: begin
            if (off_req) begin
               nxt_mode = ST_OFF;
            end else if (off_ext_pend_ff && osc_stable && !osc_stable_prev_ff) begin
               nxt_mode = ST_EXT;
            end else if (clk_sel == `FCM_SEL_BYP && ref_ok) begin
               nxt_mode = ST_BYP;
            end else if (clk_sel == `FCM_SEL_EXT && ref_ok && osc_stable) begin
               nxt_mode = ST_EXT;
            end else if (clk_sel == `FCM_SEL_INT) begin
               nxt_mode = ST_INT_UNLK;
            end
         end
         ST_INT_UNLK: begin
            if (off_req) begin
               nxt_mode = ST_OFF;
            end else if (clk_sel != `FCM_SEL_INT) begin
               nxt_mode = ST_SELF;
            end else if (count_error_valid && err_in_lock && lock_cnt_ff == LOCK_SAMPLES - 1) begin
               nxt_mode = ST_INT_LOCK;
            end
         end
         ST_INT_LOCK: begin
            if (off_req) begin
               nxt_mode = ST_OFF;
            end else if (clk_sel != `FCM_SEL_INT) begin
               nxt_mode = ST_SELF;
            end else if (count_error_valid && err_out_unlock) begin
               nxt_mode = ST_INT_UNLK;
            end
         end
         ST_BYP: begin
            // A fallback taken on clock loss holds while the loss lasts, so that the
            // engaged and bypassed modes do not chase each other every few cycles.
            if (off_req) begin
               nxt_mode = ST_OFF;
            end else if (!ref_ok || (clk_sel != `FCM_SEL_BYP && !(clk_sel == `FCM_SEL_EXT && clk_lost))) begin
               nxt_mode = ST_SELF;
            end
         end
         ST_EXT: begin
            if (off_req) begin
               nxt_mode = ST_OFF;
            end else if (clk_lost && ref_ok) begin
               nxt_mode = ST_BYP;
            end else if (clk_sel != `FCM_SEL_EXT || !ref_ok) begin
               nxt_mode = ST_SELF;
            end
         end
         ST_OFF: begin
            if (!off_req) begin
               nxt_mode = off_clock_select_field_byp_ff ? ST_BYP : ST_SELF;
            end
         end
         default: begin
            nxt_mode = ST_SELF;
         end
      endcase
   end

   // Consecutive in-window sample count while unlocked.
   always @* begin
      nxt_lock_cnt = lock_cnt_ff;
      if (mode_ff != ST_INT_UNLK) begin
         nxt_lock_cnt = {CNT_W{1'b0}};
      end else if (count_error_valid) begin
         if (err_in_lock) begin
            nxt_lock_cnt = lock_cnt_ff + 8'h01;
         end else begin
            nxt_lock_cnt = {CNT_W{1'b0}};
         end
      end
   end

   always @* begin
      sum = acc_ff + {{2{count_error[ERR_W-1]}}, count_error};
   end

   // Interrupt events, one cycle each.
   always @* begin
      evt = {IW{1'b0}};
      evt[`FCM_INT_LOCK_GAIN] = (mode_ff == ST_INT_UNLK) && (nxt_mode == ST_INT_LOCK);
      evt[`FCM_INT_LOCK_LOST] = (mode_ff == ST_INT_LOCK) && (nxt_mode == ST_INT_UNLK);
      evt[`FCM_INT_CLK_LOSS] = (mode_ff == ST_EXT) && (nxt_mode == ST_BYP);
      evt[`FCM_INT_MODE_CHG] = (nxt_mode != mode_ff);
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_ff <= ST_SELF;
         lock_cnt_ff <= {CNT_W{1'b0}};
         off_clock_select_field_byp_ff <= 1'b0;
         off_clock_select_field_ext_ff <= 1'b0;
         off_ext_pend_ff <= 1'b0;
      end else begin
         mode_ff <= nxt_mode;
         lock_cnt_ff <= nxt_lock_cnt;
         // Select and reference status are frozen on the way into off mode.
         if (nxt_mode == ST_OFF && mode_ff != ST_OFF) begin
            off_clock_select_field_byp_ff <= (clk_sel == `FCM_SEL_BYP) && ref_ok;
            off_clock_select_field_ext_ff <= (clk_sel == `FCM_SEL_EXT);
         end
         if (mode_ff == ST_OFF && nxt_mode == ST_SELF) begin
            off_ext_pend_ff <= off_clock_select_field_ext_ff;
         end else if (mode_ff != ST_SELF || nxt_mode != ST_SELF) begin
            off_ext_pend_ff <= 1'b0;
         end
      end
   end

   // Loop filter: every sample while unlocked, averaged over four when locked.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         avg_cnt_ff <= 2'h0;
         acc_ff <= {(ERR_W+2){1'b0}};
         filter_value_ff <= {ERR_W{1'b0}};
      end else if (mode_ff == ST_INT_LOCK) begin
         if (count_error_valid) begin
            if (avg_cnt_ff == 2'h3) begin
               filter_value_ff <= sum[ERR_W+1:`FCM_AVG_SHIFT];
               acc_ff <= {(ERR_W+2){1'b0}};
            end else begin
               acc_ff <= sum;
            end
            avg_cnt_ff <= avg_cnt_ff + 2'h1;
         end
      end else begin
         avg_cnt_ff <= 2'h0;
         acc_ff <= {(ERR_W+2){1'b0}};
         if (count_error_valid && (mode_ff == ST_INT_UNLK || mode_ff == ST_EXT)) begin
            filter_value_ff <= count_error;
         end
      end
   end

   // Oscillator, reference generator and loop reference enables and the lock flag follow the mode; select, range and multiplier follow the control register.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dco_enable_ff <= 1'b1;
         ref_gen_enable_ff <= 1'b1;
         loop_ext_ref_ff <= 1'b0;
         ref_select_ff <= 1'b0;
         range_ff <= 1'b0;
         mult_factor_ff <= 3'h0;
         locked_ff <= 1'b0;
      end else begin
         dco_enable_ff <= (nxt_mode != ST_BYP) && (nxt_mode != ST_OFF);
         ref_gen_enable_ff <= (nxt_mode != ST_BYP) && (nxt_mode != ST_EXT) && (nxt_mode != ST_OFF);
         loop_ext_ref_ff <= (nxt_mode == ST_EXT);
         ref_select_ff <= ctrl_ff[`FCM_CTRL_REFSEL_BIT];
         range_ff <= ctrl_ff[`FCM_CTRL_RANGE_BIT];
         mult_factor_ff <= ctrl_ff[`FCM_CTRL_MULT_LSB+2:`FCM_CTRL_MULT_LSB];
         locked_ff <= (nxt_mode == ST_INT_LOCK);
      end
   end

   // The external reference drives the output only in bypassed mode; the limit on
   // its rate in engaged mode is left to the board.
   fcm_clk_divider #(
      .RDIV_W(`FCM_RDIV_W)
   ) u_div (
      .hclk(hclk),
      .hresetn(hresetn),
      .src_lvl(mode_ff == ST_BYP ? sync_ff[4] : sync_ff[3]),
      .rdiv_sel(rdiv_sel),
      .div_out_ff(generator_output_clk)
   );

   // Register bus. Writes take no wait state; reads take one so that a read right
   // behind a write sees the written value.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_ff <= 1'b0;
         rd_pend_ff <= 1'b0;
         addr_ff <= 8'h00;
         hreadyout_ff <= 1'b1;
         hresp_ff <= 1'b0;
         hrdata_ff <= 32'h0000_0000;
      end else begin
         if (hreadyout_ff) begin
            wr_pend_ff <= addr_take && hwrite;
            rd_pend_ff <= addr_take && !hwrite;
            hreadyout_ff <= !(addr_take && !hwrite);
            if (addr_take) begin
               addr_ff <= haddr;
            end
         end else begin
            rd_pend_ff <= 1'b0;
            hreadyout_ff <= 1'b1;
         end
         if (rd_pend_ff) begin
            case (addr_ff)
               `FCM_OFF_CTRL: hrdata_ff <= ctrl_ff;
               `FCM_OFF_STATUS: hrdata_ff <= {24'h000000, osc_stable, clk_lost, ref_ok, locked_ff, 1'b0, mode_ff};
               `FCM_OFF_INT_STATUS: hrdata_ff <= {{(32-IW){1'b0}}, int_stat_ff};
               `FCM_OFF_INT_MASK: hrdata_ff <= {{(32-IW){1'b0}}, int_mask_ff};
               `FCM_OFF_FILTER: hrdata_ff <= {{(32-ERR_W){filter_value_ff[ERR_W-1]}}, filter_value_ff};
               default: hrdata_ff <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Control, mask and sticky interrupt status; a new event wins over its clear.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_ff <= `FCM_CTRL_RESET;
         int_mask_ff <= `FCM_INT_MASK_RESET;
         int_stat_ff <= {IW{1'b0}};
         irq_ff <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl_ff <= hwdata & 32'h0000_771F;
         end
         if (wr_int_mask) begin
            int_mask_ff <= hwdata[IW-1:0];
         end
         if (wr_int_stat) begin
            int_stat_ff <= (int_stat_ff & ~hwdata[IW-1:0]) | evt;
         end else begin
            int_stat_ff <= int_stat_ff | evt;
         end
         irq_ff <= |(int_stat_ff & int_mask_ff);
      end
   end
endmodule

// [tb/fcm_mode_chk_assertions.sv]
// Concurrent checks on mode, lock, filter and bus timing of the mode controller.
`timescale 1ns/100ps
module fcm_mode_chk #(
   parameter ERR_W = 16,
   parameter LOCK_MAX = 8,
   parameter LOCK_MIN = -8,
   parameter UNLOCK_MAX = 16,
   parameter UNLOCK_MIN = -16
) (
   // Clock and reset
   input logic hclk,
   input logic hresetn,
   // Bus
   input logic hsel,
   input logic [1:0] htrans,
   input logic hwrite,
   input logic hready,
   input logic hreadyout_ff,
   input logic hresp_ff,
   // Loop side
   input logic signed [ERR_W-1:0] count_error,
   input logic count_error_valid,
   input logic dco_enable_ff,
   input logic ref_gen_enable_ff,
   input logic loop_ext_ref_ff,
   input logic signed [ERR_W-1:0] filter_value_ff,
   input logic [2:0] mode_ff,
   input logic locked_ff
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   lock_flag_a: assert property (locked_ff == (mode_ff == 3'h2))
      else $error("Lock flag differs from mode.");
   lock_entry_a: assert property ($changed(mode_ff) && mode_ff == 3'h2 |-> $past(mode_ff) == 3'h1)
      else $error("Locked state entered without unlocked state.");
   stay_unlocked_a: assert property (mode_ff == 3'h1 && count_error_valid
      && (count_error >= LOCK_MAX || count_error <= LOCK_MIN) |=> mode_ff != 3'h2)
      else $error("Locked on an out of window sample.");
   unlock_exit_a: assert property (mode_ff == 3'h2 && count_error_valid
      && (count_error > UNLOCK_MAX || count_error < UNLOCK_MIN) |=> mode_ff != 3'h2)
      else $error("Stayed locked past the unlock window.");
   filter_hold_a: assert property (mode_ff == 3'h2 && $past(mode_ff) == 3'h2 && !$past(count_error_valid)
      && !$past(count_error_valid, 2) |-> $stable(filter_value_ff))
      else $error("Filter moved with no sample.");
   bypass_osc_off_a: assert property (mode_ff == 3'h3 && $past(mode_ff) == 3'h3
      |-> !dco_enable_ff && !ref_gen_enable_ff)
      else $error("Oscillator on in bypassed mode.");
   ext_loop_ref_a: assert property (mode_ff == 3'h4 && $past(mode_ff) == 3'h4 |-> loop_ext_ref_ff)
      else $error("Loop not on external reference.");
   bypass_entry_a: assert property ($changed(mode_ff) && mode_ff == 3'h3
      |-> $past(mode_ff) inside {3'h0, 3'h4, 3'h5})
      else $error("Bypassed mode entered from a wrong mode.");
   read_wait_a: assert property (hsel && hready && htrans[1] && !hwrite && hreadyout_ff
      |=> !hreadyout_ff ##1 hreadyout_ff)
      else $error("Read wait state wrong.");
   okay_resp_a: assert property (hresp_ff == 1'b0)
      else $error("Response not OKAY.");
endmodule
bind fcm_mode_ctrl fcm_mode_chk #(.ERR_W(ERR_W), .LOCK_MAX(LOCK_MAX), .LOCK_MIN(LOCK_MIN),
   .UNLOCK_MAX(UNLOCK_MAX), .UNLOCK_MIN(UNLOCK_MIN)) u_chk (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout_ff(hreadyout_ff),
   .hresp_ff(hresp_ff), .count_error(count_error), .count_error_valid(count_error_valid),
   .dco_enable_ff(dco_enable_ff), .ref_gen_enable_ff(ref_gen_enable_ff), .loop_ext_ref_ff(loop_ext_ref_ff),
   .filter_value_ff(filter_value_ff), .mode_ff(mode_ff), .locked_ff(locked_ff));

// [tb/fcm_xtal_model.sv]
// Behavioural external reference source driving the reference clock and status pins.
`timescale 1ns/100ps
module fcm_xtal_model #(
   parameter int HALF_NS = 80,
   parameter int START_CYC = 4
) (
   // Enable from the bench
   input logic en,
   // Reference clock and status
   output logic ref_clk,
   output logic ref_ok
);
   int cyc = 0;
   // A half period of 50 ns or more keeps the reference at or below 10 MHz.
   initial begin
      ref_clk = 1'b0;
      ref_ok = 1'b0;
      #3;
      forever begin
         #(HALF_NS);
         if (en) begin
            ref_clk = ~ref_clk;
            cyc = cyc + 1;
         end else begin
            ref_clk = 1'b0;
            cyc = 0;
         end
         ref_ok = (cyc >= 2 * START_CYC);
      end
   end
endmodule

// [tb/testbench.sv]
// Self-checking bench for the clock generator mode controller.
`timescale 1ns/100ps
`include "fcm_consts.vh"
module testbench;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic [31:0] hwdata = 32'h0;
   logic xt_en = 1'b0;
   logic los = 1'b0;
   logic osc_stb = 1'b1;
   logic oclk = 1'b0;
   logic cev = 1'b0;
   logic signed [15:0] cerr = 16'h0;
   logic rd_on = 1'b0;
   logic [31:0] exp_q[$];
   logic [31:0] msk_q[$];
   int mismatches = 0;
   int compares = 0;
   wire [31:0] hrdata_ff;
   wire hreadyout_ff, hresp_ff, dco_en, rgen_en, lref, rsel, rng, lkd, gclk, irq, xclk, xok;
   wire [2:0] mult;
   wire [2:0] mode;
   wire signed [15:0] filt;
   always #5 hclk = ~hclk;
   always #40 oclk = ~oclk;
   fcm_xtal_model u_xtal (.en(xt_en), .ref_clk(xclk), .ref_ok(xok));
   fcm_mode_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout_ff), .hrdata_ff(hrdata_ff),
      .hreadyout_ff(hreadyout_ff), .hresp_ff(hresp_ff), .ext_ref_status_pin(xok), .loss_of_clock_pin(los),
      .osc_stable_pin(osc_stb), .osc_derived_clk_pin(oclk), .ext_ref_clk_pin(xclk), .count_error(cerr),
      .count_error_valid(cev), .dco_enable_ff(dco_en), .ref_gen_enable_ff(rgen_en), .loop_ext_ref_ff(lref),
      .ref_select_ff(rsel), .range_ff(rng), .mult_factor_ff(mult), .filter_value_ff(filt), .mode_ff(mode),
      .locked_ff(lkd), .generator_output_clk(gclk), .irq_ff(irq));
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task report_and_stop;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task bus(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [31:0] m);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hreadyout_ff !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= w ? d : $urandom;
      rd_on <= !w;
      if (!w) begin
         exp_q.push_back(d & m);
         msk_q.push_back(m);
      end
      @(posedge hclk);
      while (hreadyout_ff !== 1'b1) @(posedge hclk);
      rd_on <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(a, 1'b1, d, 32'h0);
   endtask
   task st(input logic [2:0] m);
      repeat (6) @(posedge hclk);
      bus(`FCM_OFF_STATUS, 1'b0, {27'h0, m == 3'h2, 1'b0, m}, 32'h17);
   endtask
   task smp(input logic signed [15:0] v);
      cerr <= v;
      cev <= 1'b1;
      @(posedge hclk);
      cev <= 1'b0;
      @(posedge hclk);
   endtask
   task meas(input int e);
      int n;
      int k;
      logic p;
      n = 0;
      k = 0;
      p = gclk;
      while (k < 2 && n < 500) begin
         @(posedge hclk);
         #1;
         n++;
         if (!p && gclk) begin
            k++;
            if (k == 1) n = 0;
         end
         p = gclk;
      end
      chk("out_period", e, n);
      @(posedge hclk);
   endtask
   always @(posedge hclk) begin
      if (rd_on === 1'b1 && hreadyout_ff === 1'b1) chk("hrdata", exp_q.pop_front(), hrdata_ff & msk_q.pop_front());
   end
   initial begin
      #100000;
      mismatches++;
      report_and_stop;
   end
   initial begin
      void'($urandom(25333));
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      bus(`FCM_OFF_CTRL, 1'b0, 32'h0, 32'hFFFFFFFF);
      bus(`FCM_OFF_INT_MASK, 1'b0, 32'h0, 32'hFFFFFFFF);
      bus(8'h20, 1'b0, 32'h0, 32'hFFFFFFFF);
      wr(`FCM_OFF_CTRL, 32'hFFFFFFFF);
      bus(`FCM_OFF_CTRL, 1'b0, 32'h771F, 32'hFFFFFFFF);
      wr(`FCM_OFF_CTRL, 32'h2);
      st(3'h0);
      $display("test registers done");
      xt_en <= 1'b1;
      repeat (100) @(posedge hclk);
      wr(`FCM_OFF_CTRL, 32'h1002);
      st(3'h3);
      chk("dco_enable", 0, dco_en);
      chk("ref_gen_enable", 0, rgen_en);
      meas(32);
      $display("test bypassed done");
      wr(`FCM_OFF_INT_STATUS, 32'hF);
      wr(`FCM_OFF_CTRL, 32'h350D);
      st(3'h1);
      chk("ref_select", 1, rsel);
      chk("range", 1, rng);
      chk("mult", 5, mult);
      repeat (3) smp($urandom_range(14) - 7);
      smp(16'sd8);
      st(3'h1);
      repeat (3) smp($urandom_range(14) - 7);
      st(3'h1);
      smp(16'sd1);
      st(3'h2);
      chk("filter", 1, filt);
      meas(64);
      for (int s = 0; s < 2; s++) begin
         for (int i = 0; i < 8; i++) smp(s ? -(4 + i % 4) : 4 + i % 4);
         chk("filter", s ? -6 : 5, filt);
         bus(`FCM_OFF_FILTER, 1'b0, s ? 32'hFFFFFFFA : 32'h5, 32'hFFFFFFFF);
      end
      smp(16'sd12);
      st(3'h2);
      smp(16'sd17);
      st(3'h1);
      bus(`FCM_OFF_INT_STATUS, 1'b0, 32'h3, 32'h3);
      chk("irq", 0, irq);
      wr(`FCM_OFF_INT_MASK, 32'h2);
      repeat (3) @(posedge hclk);
      chk("irq", 1, irq);
      wr(`FCM_OFF_INT_STATUS, 32'h2);
      repeat (3) @(posedge hclk);
      chk("irq", 0, irq);
      $display("test internal done");
      wr(`FCM_OFF_CTRL, 32'h0503);
      st(3'h4);
      chk("loop_ext_ref", 1, lref);
      los <= 1'b1;
      st(3'h3);
      bus(`FCM_OFF_INT_STATUS, 1'b0, 32'h4, 32'h4);
      los <= 1'b0;
      $display("test external done");
      wr(`FCM_OFF_CTRL, 32'h12);
      st(3'h5);
      wr(`FCM_OFF_CTRL, 32'h2);
      st(3'h3);
      osc_stb <= 1'b0;
      wr(`FCM_OFF_CTRL, 32'h13);
      st(3'h5);
      wr(`FCM_OFF_CTRL, 32'h3);
      st(3'h0);
      osc_stb <= 1'b1;
      st(3'h4);
      $display("test off done");
      report_and_stop;
   end
endmodule
